// [cmig_consts.svh]
// cmig constants: offsets, field positions, reset values and timing counts
`ifndef CMIG_CONSTS_SVH
`define CMIG_CONSTS_SVH

`define CMIG_CLK_PERIOD_NS   20
`define CMIG_SETTLE_NS       40
`define CMIG_SETTLE_CYC      ((`CMIG_SETTLE_NS + `CMIG_CLK_PERIOD_NS - 1) / `CMIG_CLK_PERIOD_NS)
`define CMIG_FETCH_WAITS     1
`define CMIG_SYNC_W          39
// synchroniser reset: idle pin levels, on-board memories deselected
`define CMIG_SYNC_RST        39'h7FFFFE0000

`define CMIG_MEM_AW          15
`define CMIG_DEV_SEL_BIT     15
`define CMIG_ONCHIP_LIMIT    16'h0040
`define CMIG_SER_A7          7
`define CMIG_SER_A6          6

`define CMIG_REG_CMD         2'h0
`define CMIG_REG_VEC         2'h3
`define CMIG_CMD_FLAG_BIT    7
`define CMIG_CMD_CLR_IP_BIT  0
`define CMIG_CMD_CLR_IUS_BIT 1
`define CMIG_CMD_DLC_BIT     2
`define CMIG_REG_RST         8'h00

`endif

// [cmig_pkg.sv]
// cmig package: bus carrier structs and state encoding
package cmig_pkg;

  typedef struct packed {
    logic [15:0] addr;
    logic        mem_request_n;
    logic        io_request_n;
    logic        rd_n;
    logic        wr_n;
    logic        fetch_cycle_n;
  } cmig_cpu_bus_t;

  typedef struct packed {
    logic [14:0] addr;
    logic        ram_chip_select_n;
    logic        rom_chip_select_n;
    logic        oe_n;
    logic        we_n;
  } cmig_mem_ctl_t;

  typedef struct packed {
    logic periph_read_strobe_n;
    logic periph_write_strobe_n;
    logic periph_chip_select_n;
    logic serial_ctrl_chip_select_n;
  } cmig_io_ctl_t;

  typedef struct packed {
    logic chan_sel;
    logic ctrl_data_sel;
  } cmig_reg_sel_t;

  typedef enum logic [2:0] {
    CMIG_S_IDLE   = 3'b001,
    CMIG_S_SETTLE = 3'b010,
    CMIG_S_ACTIVE = 3'b100
  } cmig_ser_state_t;

endpackage : cmig_pkg

// [cmig_sync.sv]
// cmig two flip-flop synchroniser for a vector of pin levels
module cmig_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic         ref_clk_i,
  input  wire logic         rst_n_i,
  // levels
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end else begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end

  assign sync_o = sync_r;

endmodule : cmig_sync

// [cmig_waitgen.sv]
// cmig opcode fetch wait state generator
`include "cmig_consts.svh"
module cmig_waitgen (
  // clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  // control
  input  wire logic enable_i,
  input  wire logic fetch_start_i,
  // wait request
  output logic      wait_n_o
);

  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic       wait_n_r;

  // load on fetch start, one clock per wait state
  assign cnt_nxt = (enable_i && fetch_start_i) ? 4'(`CMIG_FETCH_WAITS) :
                   (cnt_r != 4'h0) ? cnt_r - 4'h1 : 4'h0;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      cnt_r    <= 4'h0;
      wait_n_r <= 1'b1;
    end else begin
      cnt_r    <= cnt_nxt;
      wait_n_r <= (cnt_nxt == 4'h0);
    end
  end

  assign wait_n_o = wait_n_r;

endmodule : cmig_waitgen

// [cmig_top.sv]
// cmig top: memory and i/o decode glue with the serial controller bus end
//
// Function
// - memory select only when io request inactive
// - output enable follows read, write enable follows write
// - A15 plus user select gives RAM/ROM selects
// - fifteen low address bits to each 32KB device
// - fetch waits only with indicator on, no legacy
// - peripheral strobes from io request with read/write
// - legacy peripheral select decoded from address only
// - never select external parts in on-chip block
// - serial select needs A7, A6 and user select
// - 8-bit data bus, released when not reading
// - channel and control/data inputs pick register
// - read and write together reset the controller
// - vector driven only with acknowledge and read
// - interrupt request is active-low open drain
// - daisy chain enable in and enable out
// - serial controller strobes synchronised and settled before use
// - acknowledge read also sets under-service flag
`include "cmig_consts.svh"
module cmig_top (
  // clock and reset
  input  wire logic                   ref_clk_i,
  input  wire logic                   rst_n_i,
  // processor bus
  input  wire cmig_pkg::cmig_cpu_bus_t cpu_bus_i,
  input  wire logic                   irq_acknowledge_n_i,
  // board options
  input  wire logic                   user_ram_select_n_i,
  input  wire logic                   user_rom_select_n_i,
  input  wire logic                   user_io_select_i,
  input  wire logic                   fetch_indicator_enable_i,
  input  wire logic                   legacy_periph_present_i,
  // serial controller side
  input  wire cmig_pkg::cmig_reg_sel_t reg_sel_i,
  input  wire logic [7:0]             data_i,
  input  wire logic                   serial_event_i,
  input  wire logic                   chain_enable_in_i,
  // memory and peripheral strobes
  output cmig_pkg::cmig_mem_ctl_t     mem_ctl_o,
  output cmig_pkg::cmig_io_ctl_t      io_ctl_o,
  output logic                        wait_n_o,
  // serial controller pins
  output logic [7:0]                  data_o,
  output logic                        data_oe_o,
  output logic                        irq_n_o,
  output logic                        irq_oe_o,
  output logic                        chain_enable_out_o
);
  import cmig_pkg::*;

  function automatic logic [1:0] reg_index(input cmig_reg_sel_t sel);
    reg_index = {sel.chan_sel, sel.ctrl_data_sel};
  endfunction : reg_index

  function automatic logic mem_hit(input logic dev_match, input logic on_board, input logic io_off);
    mem_hit = dev_match && on_board && io_off;
  endfunction : mem_hit

  function automatic logic strobe_n(input logic req, input logic strb_n);
    strobe_n = !(req && !strb_n);
  endfunction : strobe_n

  // pin synchronisation
  logic [`CMIG_SYNC_W-1:0] pins_async;
  logic [`CMIG_SYNC_W-1:0] pins_sync;
  cmig_cpu_bus_t           bus;
  cmig_reg_sel_t           sel;
  logic [7:0]              din;
  logic                    ack_n;
  logic                    usr_ram_n;
  logic                    usr_rom_n;
  logic                    usr_io;
  logic                    fie;
  logic                    legacy;
  logic                    evt;
  logic                    chain_enable_in;

  assign pins_async = {cpu_bus_i,
                       irq_acknowledge_n_i,
                       user_ram_select_n_i,
                       user_rom_select_n_i,
                       user_io_select_i,
                       fetch_indicator_enable_i,
                       legacy_periph_present_i,
                       reg_sel_i,
                       data_i,
                       serial_event_i,
                       chain_enable_in_i};

  cmig_sync #(.W(`CMIG_SYNC_W), .RST_VAL(`CMIG_SYNC_RST)) u_sync (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .async_i   (pins_async),
    .sync_o    (pins_sync)
  );

  assign {bus,
          ack_n,
          usr_ram_n,
          usr_rom_n,
          usr_io,
          fie,
          legacy,
          sel,
          din,
          evt,
          chain_enable_in} = pins_sync;

  // memory decode
  wire io_idle  = bus.io_request_n;
  wire dev_hi   = bus.addr[`CMIG_DEV_SEL_BIT];
  wire ram_hit  = mem_hit(dev_hi, usr_ram_n, io_idle);
  wire rom_hit  = mem_hit(!dev_hi, usr_rom_n, io_idle);

  cmig_mem_ctl_t mem_nxt;
  assign mem_nxt.addr              = bus.addr[`CMIG_MEM_AW-1:0];
  assign mem_nxt.ram_chip_select_n = !ram_hit;
  assign mem_nxt.rom_chip_select_n = !rom_hit;
  assign mem_nxt.oe_n              = bus.rd_n;
  assign mem_nxt.we_n              = bus.wr_n;

  // i/o decode
  wire io_act     = !bus.io_request_n;
  wire onchip_hit = (bus.addr < `CMIG_ONCHIP_LIMIT);
  wire ser_range  = bus.addr[`CMIG_SER_A7] && bus.addr[`CMIG_SER_A6];
  wire ser_addr   = ser_range && usr_io;
  wire ser_cs     = ser_addr && io_act;
  wire ext_addr   = !onchip_hit && !ser_range;
  wire ext_cs     = legacy ? ext_addr : (ext_addr && io_act);

  cmig_io_ctl_t io_nxt;
  assign io_nxt.periph_read_strobe_n      = strobe_n(io_act, bus.rd_n);
  assign io_nxt.periph_write_strobe_n     = strobe_n(io_act, bus.wr_n);
  assign io_nxt.periph_chip_select_n      = !ext_cs;
  assign io_nxt.serial_ctrl_chip_select_n = !ser_cs;

  // opcode fetch wait states
  logic fetch_seen_r;
  wire  fetch_now   = !bus.fetch_cycle_n && !bus.mem_request_n;
  wire  fetch_start = fetch_now && !fetch_seen_r;
  wire  wait_en     = fie && !legacy;

  cmig_waitgen u_wait (
    .ref_clk_i     (ref_clk_i),
    .rst_n_i       (rst_n_i),
    .enable_i      (wait_en),
    .fetch_start_i (fetch_start),
    .wait_n_o      (wait_n_o)
  );

  // serial controller bus end
  wire rd_act  = !bus.rd_n;
  wire wr_act  = !bus.wr_n;
  wire ack_act = !ack_n;
  wire any_req = rd_act || wr_act || (ack_act && rd_act);

  cmig_ser_state_t state_r;
  cmig_ser_state_t state_nxt;
  logic [2:0]      cnt_r;
  logic [2:0]      cnt_nxt;
  logic [7:0]      regs_r [4];
  logic            ip_r;
  logic            ius_r;
  logic            dlc_r;
  logic            vec_rd_r;
  logic [7:0]      dout_r;
  logic            doe_r;
  logic            ieo_r;
  logic            irq_oe_r;
  cmig_mem_ctl_t   mem_r;
  cmig_io_ctl_t    io_r;

  wire settled   = (state_r == CMIG_S_SETTLE) && (cnt_r == 3'(`CMIG_SETTLE_CYC - 1));
  wire go        = settled && any_req;
  wire chip_rst  = go && rd_act && wr_act;
  wire do_wr     = go && !chip_rst && wr_act && ser_cs;
  wire do_ack    = go && !chip_rst && ack_act && rd_act && chain_enable_in && ip_r;
  wire do_rd     = go && !chip_rst && rd_act && !ack_act && ser_cs;
  wire [1:0] idx = reg_index(sel);
  wire cmd_wr    = do_wr && (idx == `CMIG_REG_CMD) && din[`CMIG_CMD_FLAG_BIT];

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    case (state_r)
      CMIG_S_IDLE: begin
        cnt_nxt = 3'h0;
        if (any_req) begin
          state_nxt = CMIG_S_SETTLE;
        end
      end
      CMIG_S_SETTLE: begin
        cnt_nxt = cnt_r + 3'h1;
        if (!any_req) begin
          state_nxt = CMIG_S_IDLE;
        end else if (settled) begin
          state_nxt = CMIG_S_ACTIVE;
        end
      end
      CMIG_S_ACTIVE: begin
        if (!rd_act && !wr_act) begin
          state_nxt = CMIG_S_IDLE;
        end
      end
      default: begin
        state_nxt = CMIG_S_IDLE;
      end
    endcase
  end

  // read data: control slots show pending and under-service
  wire [7:0] rd_word = sel.ctrl_data_sel ? regs_r[idx] : {regs_r[idx][7:2], ius_r, ip_r};
  wire [7:0] dout_nxt = do_ack ? regs_r[`CMIG_REG_VEC] : do_rd ? rd_word : dout_r;
  wire rd_hold  = (state_r == CMIG_S_ACTIVE) && rd_act && (vec_rd_r ? ack_act : ser_cs);
  wire doe_nxt  = (do_ack || do_rd || (doe_r && rd_hold)) && !chip_rst;

  // flags: hardware set wins over command clear
  wire ip_nxt  = !chip_rst && (evt || (ip_r && !(cmd_wr && din[`CMIG_CMD_CLR_IP_BIT])));
  wire ius_nxt = !chip_rst && (do_ack || (ius_r && !(cmd_wr && din[`CMIG_CMD_CLR_IUS_BIT])));
  wire dlc_nxt = chip_rst ? 1'b0 : cmd_wr ? din[`CMIG_CMD_DLC_BIT] : dlc_r;

  // daisy chain: pending blocks the chain only during acknowledge
  wire ieo_nxt = chain_enable_in && !ius_nxt && !dlc_nxt && !(ack_act && ip_nxt);
  wire irq_nxt = ip_nxt && !ius_nxt && chain_enable_in;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state_r <= CMIG_S_IDLE;
      cnt_r   <= 3'h0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || chip_rst) begin
      for (int i = 0; i < 4; i++) begin
        regs_r[i] <= `CMIG_REG_RST;
      end
    end else if (do_wr && !cmd_wr) begin
      regs_r[idx] <= din;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ip_r     <= 1'b0;
      ius_r    <= 1'b0;
      dlc_r    <= 1'b0;
      vec_rd_r <= 1'b0;
      dout_r   <= 8'h00;
      doe_r    <= 1'b0;
      ieo_r    <= 1'b0;
      irq_oe_r <= 1'b0;
    end else begin
      ip_r     <= ip_nxt;
      ius_r    <= ius_nxt;
      dlc_r    <= dlc_nxt;
      vec_rd_r <= go ? do_ack : vec_rd_r;
      dout_r   <= dout_nxt;
      doe_r    <= doe_nxt;
      ieo_r    <= ieo_nxt;
      irq_oe_r <= irq_nxt;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      mem_r        <= '1;
      io_r         <= '1;
      fetch_seen_r <= 1'b0;
    end else begin
      mem_r        <= mem_nxt;
      io_r         <= io_nxt;
      fetch_seen_r <= fetch_now;
    end
  end

  assign mem_ctl_o          = mem_r;
  assign io_ctl_o           = io_r;
  assign data_o             = dout_r;
  assign data_oe_o          = doe_r;
  assign irq_n_o            = 1'b0;
  assign irq_oe_o           = irq_oe_r;
  assign chain_enable_out_o = ieo_r;

endmodule : cmig_top

// [cmig_top_assertions.sv]
// cmig checker: port relations of the decode glue and serial controller end
module cmig_top_chk (
  // clock and reset
  input wire logic                    ref_clk_i,
  input wire logic                    rst_n_i,
  // watched inputs
  input wire cmig_pkg::cmig_cpu_bus_t cpu_bus_i,
  input wire logic                    user_ram_select_n_i,
  input wire logic                    user_rom_select_n_i,
  input wire logic                    user_io_select_i,
  input wire logic                    fetch_indicator_enable_i,
  input wire logic                    legacy_periph_present_i,
  input wire logic                    chain_enable_in_i,
  // watched outputs
  input wire cmig_pkg::cmig_mem_ctl_t mem_ctl_o,
  input wire cmig_pkg::cmig_io_ctl_t  io_ctl_o,
  input wire logic                    wait_n_o,
  input wire logic                    data_oe_o,
  input wire logic                    irq_n_o,
  input wire logic                    irq_oe_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import cmig_pkg::*;
  logic [2:0] up_r;
  wire        ok;
  // ok once the three cycle decode lag only sees post-reset inputs
  assign ok = up_r[2];
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) up_r <= 3'h0;
    else if (!up_r[2]) up_r <= up_r + 3'h1;
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_one_wait;
    !wait_n_o ##1 wait_n_o;
  endsequence
  property p_mem_io;
    ok && !(mem_ctl_o.ram_chip_select_n && mem_ctl_o.rom_chip_select_n) |-> $past(cpu_bus_i.io_request_n, 3);
  endproperty
  property p_strobes;
    ok |-> mem_ctl_o.oe_n == $past(cpu_bus_i.rd_n, 3) && mem_ctl_o.we_n == $past(cpu_bus_i.wr_n, 3);
  endproperty
  property p_ram_cs;
    ok |-> mem_ctl_o.ram_chip_select_n == !($past(cpu_bus_i.addr[15], 3) && $past(user_ram_select_n_i, 3)
                                            && $past(cpu_bus_i.io_request_n, 3));
  endproperty
  property p_addr;
    ok |-> mem_ctl_o.addr == $past(cpu_bus_i.addr[14:0], 3);
  endproperty
  property p_prd;
    ok |-> io_ctl_o.periph_read_strobe_n == ($past(cpu_bus_i.io_request_n, 3) || $past(cpu_bus_i.rd_n, 3));
  endproperty
  property p_onchip;
    ok && !io_ctl_o.periph_chip_select_n |-> $past(cpu_bus_i.addr, 3) >= 16'h0040;
  endproperty
  property p_ser_cs;
    ok |-> io_ctl_o.serial_ctrl_chip_select_n == !($past(cpu_bus_i.addr[7], 3) && $past(cpu_bus_i.addr[6], 3)
                                                   && $past(user_io_select_i, 3) && !$past(cpu_bus_i.io_request_n, 3));
  endproperty
  property p_wait_one;
    $fell(wait_n_o) |-> s_one_wait;
  endproperty
  property p_wait_en;
    ok && !wait_n_o |-> $past(fetch_indicator_enable_i, 3) && !$past(legacy_periph_present_i, 3);
  endproperty
  property p_drive;
    data_oe_o |-> !$past(cpu_bus_i.rd_n, 3);
  endproperty
  property p_irq;
    ok && irq_oe_o |-> !irq_n_o && $past(chain_enable_in_i, 3);
  endproperty
  a_mem_io: assert property (p_mem_io) else $error("memory selected in io cycle");
  a_strobes: assert property (p_strobes) else $error("memory strobes wrong");
  a_ram_cs: assert property (p_ram_cs) else $error("ram select wrong");
  a_addr: assert property (p_addr) else $error("memory address wrong");
  a_prd: assert property (p_prd) else $error("peripheral read strobe wrong");
  a_onchip: assert property (p_onchip) else $error("select in on-chip block");
  a_ser_cs: assert property (p_ser_cs) else $error("serial select wrong");
  a_wait_one: assert property (p_wait_one) else $error("wait not one cycle");
  a_wait_en: assert property (p_wait_en) else $error("wait while disabled");
  a_drive: assert property (p_drive) else $error("data driven without read");
  a_irq: assert property (p_irq) else $error("interrupt pull wrong");
endmodule : cmig_top_chk

bind cmig_top cmig_top_chk u_chk (.*);

// [cmig_cpu_model.sv]
// cmig processor model: drives memory, io and acknowledge bus cycles
module cmig_cpu_model (
  // clock and data bus
  input  wire logic                    ref_clk_i,
  input  wire logic [7:0]              bus_i,
  input  wire logic                    bus_oe_i,
  // processor pins
  output cmig_pkg::cmig_cpu_bus_t      cpu_o,
  output logic                         ack_n_o,
  output logic [7:0]                   d_o,
  output logic                         d_oe_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import cmig_pkg::*;
  logic [7:0] q;
  logic       qv;
  initial begin
    cpu_o = '1;
    ack_n_o = 1'b1;
    d_o = 8'h00;
    d_oe_o = 1'b0;
  end
  // s is {mem, io, rd, wr, fetch}
  task set(input logic [15:0] a, input logic [4:0] s, input logic ak, input logic [7:0] d);
    @(negedge ref_clk_i);
    // answer taken settled, before the pins move
    q = bus_i;
    qv = bus_oe_i;
    cpu_o = {a, s};
    ack_n_o = ak;
    d_o = d;
    d_oe_o = !s[1];
  endtask : set
  task cyc(input logic [15:0] a, input logic [4:0] s, input logic ak, input logic [7:0] d, input int n);
    set(a, s, ak, d);
    repeat (n) @(posedge ref_clk_i);
    set(16'h0000, 5'h1F, 1'b1, 8'h00);
    repeat (3) @(posedge ref_clk_i);
  endtask : cyc
endmodule : cmig_cpu_model

// [tb_cmig_top.sv]
// cmig testbench: decode table, fetch waits and serial controller accesses
module tb_cmig_top;
  timeunit 1ns;
  timeprecision 1ns;
  import cmig_pkg::*;
  typedef struct packed {
    logic [15:0] a;
    logic [3:0]  c;
    logic [3:0]  o;
    logic [3:0]  em;
    logic [3:0]  ei;
  } cmig_row_t;
  logic          ref_clk_i, rst_n_i, uram, urom, uio, fen, leg, ev, cin;
  logic          wt, oe, irq_n, irq_oe, cout, ack_n, cd_oe;
  logic [7:0]    dout, cd, dbus;
  cmig_reg_sel_t rs;
  cmig_cpu_bus_t cpu;
  cmig_mem_ctl_t mem;
  cmig_io_ctl_t  io;
  int            mismatches = 0;
  int            n_checks = 0;
  int            k;
  // row: addr, {mem,io,rd,wr}, {ram_n,rom_n,user_io,legacy}, memory strobes, io strobes
  cmig_row_t rows [11] = '{32'h8000_5E5F, 32'h1234_6EAF, 32'h8000_56DF, 32'h1234_5ADF, 32'h00C1_9ED6,
                           32'h00FF_AEEA, 32'h00C1_9CD7, 32'h0080_9ED5, 32'h003F_9ED7, 32'h0040_5F9D,
                           32'h0040_5E9F};
  assign dbus = oe ? dout : (cd_oe ? cd : ~cd);
  cmig_top dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .cpu_bus_i(cpu), .irq_acknowledge_n_i(ack_n),
    .user_ram_select_n_i(uram), .user_rom_select_n_i(urom), .user_io_select_i(uio),
    .fetch_indicator_enable_i(fen), .legacy_periph_present_i(leg), .reg_sel_i(rs), .data_i(dbus),
    .serial_event_i(ev), .chain_enable_in_i(cin), .mem_ctl_o(mem), .io_ctl_o(io), .wait_n_o(wt),
    .data_o(dout), .data_oe_o(oe), .irq_n_o(irq_n), .irq_oe_o(irq_oe), .chain_enable_out_o(cout));
  cmig_cpu_model m (.ref_clk_i(ref_clk_i), .bus_i(dbus), .bus_oe_i(oe), .cpu_o(cpu), .ack_n_o(ack_n),
    .d_o(cd), .d_oe_o(cd_oe));
  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  task chk(input logic [31:0] g, input logic [31:0] e, input string s);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %0t %s", $time, s);
    end
  endtask : chk
  task final_report;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report
  task wr(input logic [1:0] r, input logic [7:0] d, input int n);
    @(negedge ref_clk_i);
    rs = r;
    m.cyc(16'h00C0, 5'b10101, 1'b1, d, n);
  endtask : wr
  task rd(input logic [1:0] r, input logic [7:0] e);
    @(negedge ref_clk_i);
    rs = r;
    m.cyc(16'h00C0, 5'b10011, 1'b1, 8'h00, 8);
    @(negedge ref_clk_i);
    chk(m.qv, 1, "no data drive");
    chk(m.q, e, "read data");
    chk(oe, 0, "bus not released");
  endtask : rd
  task fetch(input int e);
    int c;
    c = 0;
    repeat (3) @(negedge ref_clk_i);
    fork
      m.cyc(16'h0100, 5'b01010, 1'b1, 8'h00, 4);
      repeat (8) @(negedge ref_clk_i) c += !wt;
    join
    chk(c, e, "wait count");
  endtask : fetch
  initial begin
    rst_n_i = 1'b0;
    {uram, urom, uio, fen, leg, ev, cin} = 7'h79;
    rs = '0;
    repeat (12) @(negedge ref_clk_i);
    chk({mem, io, wt, oe, irq_oe, cout}, {19'h7FFFF, 4'hF, 4'h8}, "reset values");
    rst_n_i = 1'b1;
    $display("test reset done");
    for (k = 0; k < 11; k++) begin
      @(negedge ref_clk_i);
      {uram, urom, uio, leg} = rows[k].o;
      m.set(rows[k].a, {rows[k].c, 1'b1}, 1'b1, 8'h00);
      repeat (4) @(negedge ref_clk_i);
      chk(mem[3:0], rows[k].em, "memory strobes");
      chk(mem.addr, rows[k].a[14:0], "memory address");
      chk(io, rows[k].ei, "io strobes");
      m.set(16'h0000, 5'h1F, 1'b1, 8'h00);
      repeat (3) @(negedge ref_clk_i);
    end
    {uram, urom, uio, leg} = 4'hE;
    $display("test decode done");
    fetch(1);
    fen = 1'b0;
    fetch(0);
    {fen, leg} = 2'b11;
    fetch(0);
    fen = 1'b0;
    fetch(0);
    {fen, leg} = 2'b10;
    $display("test wait done");
    wr(2'h1, 8'h12, 6);
    wr(2'h2, 8'h34, 6);
    rd(2'h1, 8'h12);
    rd(2'h2, 8'h34);
    wr(2'h3, 8'h5A, 6);
    chk(cout, 1, "chain idle");
    @(negedge ref_clk_i);
    ev = 1'b1;
    @(negedge ref_clk_i);
    ev = 1'b0;
    repeat (6) @(negedge ref_clk_i);
    chk({irq_oe, irq_n}, 2'b10, "no interrupt");
    m.cyc(16'h0000, 5'b11010, 1'b0, 8'h00, 8);
    chk(m.q, 8'h5A, "vector");
    chk({irq_oe, cout}, 2'b00, "under service");
    wr(2'h0, 8'h83, 6);
    repeat (3) @(negedge ref_clk_i);
    chk({irq_oe, cout}, 2'b01, "not cleared");
    cin = 1'b0;
    ev = 1'b1;
    @(negedge ref_clk_i);
    ev = 1'b0;
    repeat (6) @(negedge ref_clk_i);
    chk({irq_oe, cout}, 2'b00, "chain blocked");
    cin = 1'b1;
    $display("test interrupt done");
    wr(2'h1, 8'h77, 6);
    m.cyc(16'h00C0, 5'b10001, 1'b1, 8'h00, 6);
    rd(2'h1, 8'h00);
    wr(2'h1, 8'hEE, 1);
    rd(2'h1, 8'h00);
    $display("test strobes done");
    final_report;
  end
  initial begin
    repeat (5000) @(posedge ref_clk_i);
    mismatches++;
    final_report;
  end
endmodule : tb_cmig_top
